// [aeol_top.sv]
/*
  Output logic of a magnetic angle encoder: serial absolute readout,
  quadrature with index, Hall-style commutation and PWM.
  Assumes the front end answers each sample request with pos_valid and that
  mode selects come from logic on core_clk.
*/
`timescale 1ns/1ps
module aeol_top #(
  parameter int SAMPLE_CYCLES = aeol_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // Position front end
  input  wire logic [aeol_pkg::POS_W-1:0] pos_in,
  input  wire logic                     pos_valid,
  output logic                          sample_req,
  output logic                          pos_ready,
  // Serial link pins
  input  wire logic                     ssi_clk,
  input  wire logic                     frame_select_low,
  output logic                          ssi_data_out,
  output logic                          ssi_data_oe_n,
  // Mode and configuration
  input  wire logic                     inc_enable,
  input  wire logic                     comm_enable,
  input  wire logic                     pwm_enable,
  input  wire logic [2:0]               cpr_sel,
  input  wire logic [1:0]               index_width_sel,
  input  wire logic [1:0]               pole_pair_sel,
  // Incremental outputs
  output logic                          quad_a,
  output logic                          quad_b,
  output logic                          quad_index,
  output logic [aeol_pkg::STEP_W-1:0]   inc_count,
  // Commutation and PWM outputs
  output logic                          comm_u,
  output logic                          comm_v,
  output logic                          comm_w,
  output logic                          pwm_out
);

  localparam int PW  = aeol_pkg::POS_W;
  localparam int SW  = aeol_pkg::STEP_W;
  localparam int SCW = $clog2(SAMPLE_CYCLES + 1);
  localparam int TCW = $clog2(aeol_pkg::TIMEOUT_CYC + 1);
  localparam int LCW = $clog2(aeol_pkg::LOW_HOLD_CYC + 1);
  localparam int KCW = $clog2(aeol_pkg::PWM_TICK_CYC + 1);
  localparam int UCW = $clog2(aeol_pkg::PWM_UNITS + 1);
  localparam logic [SCW-1:0] SAMP_LAST = SCW'(SAMPLE_CYCLES - 1);
  localparam logic [TCW-1:0] TMO_LAST  = TCW'(aeol_pkg::TIMEOUT_CYC - 1);
  localparam logic [LCW-1:0] LOW_LAST  = LCW'(aeol_pkg::LOW_HOLD_CYC - 1);
  localparam logic [KCW-1:0] TICK_LAST = KCW'(aeol_pkg::PWM_TICK_CYC - 1);
  localparam logic [UCW-1:0] UNIT_LAST = UCW'(aeol_pkg::PWM_UNITS - 1);
  localparam logic [SW-1:0]  STEP_ONE  = SW'(1);

  function automatic logic [SW-1:0] step_of(input logic [PW-1:0] p, input logic [2:0] sel);
    logic [PW-1:0] s;
    s = p >> (aeol_pkg::STEP_BASE - sel);
    return s[SW-1:0];
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic dt_s1_q, dt_s2_q;
  logic link_data;

  always_ff @(posedge core_clk) begin
    cs_s1_q <= frame_select_low;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    ck_s1_q <= ssi_clk;
    ck_s2_q <= ck_s1_q;
    ck_s3_q <= ck_s2_q;
    dt_s1_q <= link_data;
    dt_s2_q <= dt_s1_q;
  end

  logic cs_fall;
  logic ck_fall;
  assign cs_fall = cs_s3_q & ~cs_s2_q;
  assign ck_fall = ck_s3_q & ~ck_s2_q;

  // ==========================================================================
  // Sampling
  logic [SCW-1:0] samp_cnt_q, samp_cnt_d;
  logic           req_q, req_d;
  logic [PW-1:0]  pos_q, pos_d;
  logic           ready_q, ready_d;

  always_comb begin
    samp_cnt_d = samp_cnt_q + 1'b1;
    req_d      = 1'b0;
    pos_d      = pos_q;
    ready_d    = ready_q;
    if (samp_cnt_q == SAMP_LAST) begin
      samp_cnt_d = '0;
      req_d      = 1'b1;
    end
    if (pos_valid) begin
      pos_d   = pos_in;
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      samp_cnt_q <= '0;
      req_q      <= 1'b0;
      pos_q      <= '0;
      ready_q    <= 1'b0;
    end else begin
      samp_cnt_q <= samp_cnt_d;
      req_q      <= req_d;
      pos_q      <= pos_d;
      ready_q    <= ready_d;
    end
  end

  assign sample_req = req_q;
  assign pos_ready  = ready_q;

  // ==========================================================================
  // Frame control
  aeol_pkg::aeol_frame_t state_q, state_d;
  logic [PW-1:0]  hold_q, hold_d;
  logic           tgl_q, tgl_d;
  logic [TCW-1:0] tmo_q, tmo_d;
  logic [LCW-1:0] low_q, low_d;
  logic           oe_n_q;

  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    tgl_d   = tgl_q;
    tmo_d   = tmo_q;
    low_d   = low_q;
    case (state_q)
      aeol_pkg::FR_IDLE: begin
        if (cs_fall) begin
          state_d = aeol_pkg::FR_ACTIVE;
          hold_d  = pos_q;
          tgl_d   = ~tgl_q;
          tmo_d   = '0;
          low_d   = '0;
        end
      end
      aeol_pkg::FR_ACTIVE: begin
        if (cs_s2_q) begin
          state_d = aeol_pkg::FR_IDLE;
        end else if (tmo_q == TMO_LAST) begin
          state_d = aeol_pkg::FR_ENDED;
        end else if (low_q == LOW_LAST) begin
          state_d = aeol_pkg::FR_ENDED;
        end else begin
          tmo_d = ck_fall ? '0 : tmo_q + 1'b1;
          low_d = dt_s2_q ? '0 : low_q + 1'b1;
        end
      end
      aeol_pkg::FR_ENDED: begin
        if (cs_s2_q) begin
          state_d = aeol_pkg::FR_IDLE;
        end
      end
      default: begin
        state_d = aeol_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= aeol_pkg::FR_IDLE;
      hold_q  <= '0;
      tgl_q   <= 1'b0;
      tmo_q   <= '0;
      low_q   <= '0;
      oe_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      tgl_q   <= tgl_d;
      tmo_q   <= tmo_d;
      low_q   <= low_d;
      oe_n_q  <= (state_d != aeol_pkg::FR_ACTIVE);
    end
  end

  assign ssi_data_oe_n = oe_n_q;
  assign ssi_data_out  = link_data;

  aeol_ssi_shift #(
    .W          (PW)
  ) u_shift (
    .ssi_clk    (ssi_clk),
    .core_reset (reset),
    .hold_word  (hold_q),
    .load_tgl   (tgl_q),
    .data_out   (link_data)
  );

  // ==========================================================================
  // Incremental quadrature and index
  logic [SW-1:0] step_cur;
  logic [SW-1:0] step_q;
  logic [SW-1:0] count_q, count_d;
  logic          a_q, b_q, idx_q;
  logic          a_d, b_d, idx_d;

  // Only single quarter steps between samples are counted; faster motion
  // than that is beyond what the count can follow.
  always_comb begin
    step_cur = step_of(pos_q, cpr_sel);
    a_d      = inc_enable & step_cur[1];
    b_d      = inc_enable & (step_cur[1] ^ step_cur[0]);
    idx_d    = inc_enable & (step_cur[SW-1:2] == '0)
             & (step_cur[1:0] <= index_width_sel);
    count_d  = count_q;
    if (idx_d & ~idx_q) begin
      count_d = '0;
    end else if (step_cur == step_q + STEP_ONE) begin
      count_d = count_q + 1'b1;
    end else if (step_cur == step_q - STEP_ONE) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      step_q  <= '0;
      count_q <= '0;
      a_q     <= 1'b0;
      b_q     <= 1'b0;
      idx_q   <= 1'b0;
    end else begin
      step_q  <= step_cur;
      count_q <= count_d;
      a_q     <= a_d;
      b_q     <= b_d;
      idx_q   <= idx_d;
    end
  end

  assign quad_a     = a_q;
  assign quad_b     = b_q;
  assign quad_index = idx_q;
  assign inc_count  = count_q;

  // ==========================================================================
  // Commutation
  logic [PW-1:0] elec;
  logic [PW+2:0] prod;
  logic [2:0]    sector;
  logic [2:0]    uvw_q, uvw_d;

  always_comb begin
    elec   = PW'(pos_q << pole_pair_sel);
    prod   = {3'h0, elec} * 19'h00006;
    sector = prod[PW+2:PW];
    uvw_d  = comm_enable ? aeol_pkg::HALL_PATTERN[sector] : 3'h0;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      uvw_q <= 3'h0;
    end else begin
      uvw_q <= uvw_d;
    end
  end

  assign comm_u = uvw_q[2];
  assign comm_v = uvw_q[1];
  assign comm_w = uvw_q[0];

  // ==========================================================================
  // PWM
  logic [KCW-1:0]          tick_q, tick_d;
  logic [UCW-1:0]          unit_q, unit_d;
  logic [aeol_pkg::PWM_W-1:0] duty_q, duty_d;
  logic                    pwm_q, pwm_d;

  // Duty is latched once per period so a moving shaft cannot split a pulse.
  always_comb begin
    tick_d = tick_q + 1'b1;
    unit_d = unit_q;
    duty_d = duty_q;
    if (tick_q == TICK_LAST) begin
      tick_d = '0;
      unit_d = (unit_q == UNIT_LAST) ? '0 : unit_q + 1'b1;
      if (unit_q == UNIT_LAST) begin
        duty_d = pos_q[PW-1:aeol_pkg::DUTY_LSB];
      end
    end
    pwm_d = pwm_enable & (unit_d <= {1'b0, duty_d});
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_q <= '0;
      unit_q <= '0;
      duty_q <= '0;
      pwm_q  <= 1'b0;
    end else begin
      tick_q <= tick_d;
      unit_q <= unit_d;
      duty_q <= duty_d;
      pwm_q  <= pwm_d;
    end
  end

  assign pwm_out = pwm_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_refresh;
    pos_valid |=> pos_q == $past(pos_in);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("position not refreshed");

  property p_sample;
    samp_cnt_q == SAMP_LAST |=> sample_req && samp_cnt_q == '0 ##1 !sample_req;
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample request late");

  property p_freeze;
    cs_fall && state_q == aeol_pkg::FR_IDLE
      |=> hold_q == $past(pos_q) && tgl_q != $past(tgl_q) && !ssi_data_oe_n;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("position not frozen at frame start");

  property p_timeout;
    state_q == aeol_pkg::FR_ACTIVE && !cs_s2_q && tmo_q == TMO_LAST
      |=> state_q == aeol_pkg::FR_ENDED && ssi_data_oe_n;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("frame timeout did not end frame");

  property p_restart;
    state_q == aeol_pkg::FR_ACTIVE && !cs_s2_q && ck_fall
      && tmo_q != TMO_LAST && low_q != LOW_LAST |=> tmo_q == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timeout not restarted by falling edge");

  property p_low_hold;
    state_q == aeol_pkg::FR_ACTIVE && !cs_s2_q && tmo_q != TMO_LAST
      && low_q == LOW_LAST |=> ssi_data_oe_n;
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("data held low too long");

  property p_release;
    cs_s2_q |=> ssi_data_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data not released after deselect");

  property p_cpr;
    inc_enable |=> quad_a == $past(step_cur[1]);
  endproperty
  a_cpr: assert property (p_cpr)
    else $error("quadrature not at selected resolution");

  property p_quad;
    $past(inc_enable) && inc_enable && step_q == $past(step_q) + STEP_ONE
      |-> !($changed(quad_a) && $changed(quad_b));
  endproperty
  a_quad: assert property (p_quad)
    else $error("channels not in quadrature");

  property p_index;
    quad_index |-> step_q[SW-1:2] == '0 && step_q[1:0] <= $past(index_width_sel);
  endproperty
  a_index: assert property (p_index)
    else $error("index outside reference window");

  property p_clear;
    $rose(quad_index) |-> inc_count == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("count not cleared by index");

  property p_comm;
    comm_enable |=> {comm_u, comm_v, comm_w} != 3'h0 && {comm_u, comm_v, comm_w} != 3'h7;
  endproperty
  a_comm: assert property (p_comm)
    else $error("invalid commutation pattern");

  property p_poles;
    comm_enable && pole_pair_sel == 2'h0
      |=> {comm_u, comm_v, comm_w} == aeol_pkg::HALL_PATTERN[$past(sector)];
  endproperty
  a_poles: assert property (p_poles)
    else $error("commutation sector mismatch");

  property p_pwm;
    unit_q > {1'b0, duty_q} |-> !pwm_out;
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm high beyond duty");

  c_frame:   cover property (cs_fall ##[1:100] ck_fall);
  c_timeout: cover property (state_q == aeol_pkg::FR_ACTIVE ##1 state_q == aeol_pkg::FR_ENDED);
  c_index:   cover property ($rose(quad_index));
  c_pwm:     cover property (pwm_enable && unit_q == '0 && pwm_out);

endmodule // aeol_top

// [aeol_pkg.sv]
/*
  Constants, timing figures and types shared by the angle encoder output logic.
  Assumes a 50 MHz core clock; every cycle count is derived from that rate.
*/
// Behaviour
// - The position value is refreshed continuously and made ready for the shift register.
// - Between frame start and the first rising clock edge the position is frozen for shifting.
// - The first rising clock edge of a frame presents the MSB, later edges the next bits.
// - A frame timeout, restarted at each falling clock edge, ends the frame on expiry.
// - The serial data output is never held low for longer than the low hold limit.
// - Quadrature output gives position and direction at 8 to 1024 counts per turn.
// - The index pulses once per turn at the reference, 90, 180, 270 or 360 degrees wide.
// - The incremental count is cleared by the index after each full rotation.
// - Commutation mode drives three channels that emulate motor Hall sensors.
// - The commutation pattern repeats for 1, 2, 4 or 8 pole pairs per turn.
// - PWM mode gives a duty cycle proportional to the angle, a turn spanning 0 to 1023.
// - A new position sample is taken at most every 111 microseconds.
package aeol_pkg;

  // ==========================================================================
  // Widths
  localparam int POS_W     = 16;
  localparam int STEP_W    = 12;
  localparam int STEP_BASE = 11;
  localparam int PWM_W     = 10;
  localparam int DUTY_LSB  = 6;

  // ==========================================================================
  // Timing
  localparam int CORE_CLK_MHZ      = 50;
  localparam int LATCH_LEAD_NS     = 500;
  localparam int REREAD_GAP_US     = 20;
  localparam int FRAME_TIMEOUT_US  = 20;
  localparam int LOW_HOLD_LIMIT_US = 10;
  localparam int SAMPLE_TIME_US    = 111;
  localparam int PWM_TICK_NS       = 257;

  localparam int LATCH_LEAD_CYC = (LATCH_LEAD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int REREAD_GAP_CYC = REREAD_GAP_US * CORE_CLK_MHZ;
  localparam int TIMEOUT_CYC    = FRAME_TIMEOUT_US * CORE_CLK_MHZ;
  localparam int LOW_HOLD_CYC   = LOW_HOLD_LIMIT_US * CORE_CLK_MHZ;
  localparam int SAMPLE_CYC     = SAMPLE_TIME_US * CORE_CLK_MHZ;
  localparam int PWM_TICK_CYC   = PWM_TICK_NS * CORE_CLK_MHZ / 1000;
  localparam int PWM_UNITS      = 1025;

  // ==========================================================================
  // Types and tables
  typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_ENDED} aeol_frame_t;

  // U, V, W per electrical sector, each channel high for three of six sectors
  localparam logic [5:0][2:0] HALL_PATTERN = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};

endpackage

// [aeol_ssi_shift.sv]
/*
  Serial shift stage on the controller's clock.
  Assumes the hold word and load toggle stay stable for the latch lead time
  before the first rising edge, so they are read as quasi-static values.
*/
`timescale 1ns/1ps
module aeol_ssi_shift #(
  parameter int W = aeol_pkg::POS_W
) (
  // Link clock and core reset
  input  wire logic         ssi_clk,
  input  wire logic         core_reset,
  // Frozen word from the core
  input  wire logic [W-1:0] hold_word,
  input  wire logic         load_tgl,
  // Serial data
  output logic              data_out
);

  // ==========================================================================
  // Reset crossing
  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge ssi_clk) begin
    rst_s1_q <= core_reset;
    rst_s2_q <= rst_s1_q;
  end

  // ==========================================================================
  // Shift register
  logic         seen_q, seen_d;
  logic [W-1:0] shift_q, shift_d;
  logic         data_q, data_d;
  logic         load;

  // The clock stops between frames, so a synchroniser here would miss the
  // first edge; the lead time makes the direct read safe instead.
  assign load = (load_tgl != seen_q);

  always_comb begin
    seen_d  = seen_q;
    shift_d = {shift_q[W-2:0], 1'b0};
    data_d  = shift_q[W-1];
    if (load) begin
      seen_d  = load_tgl;
      data_d  = hold_word[W-1];
      shift_d = {hold_word[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ssi_clk) begin
    if (rst_s2_q) begin
      seen_q  <= 1'b0;
      shift_q <= '0;
      data_q  <= 1'b1;
    end else begin
      seen_q  <= seen_d;
      shift_q <= shift_d;
      data_q  <= data_d;
    end
  end

  assign data_out = data_q;

  // ==========================================================================
  // Checks
  property p_msb_first;
    @(posedge ssi_clk) disable iff (rst_s2_q)
    load |=> (data_q == $past(hold_word[W-1])) && (shift_q[W-1] == $past(hold_word[W-2]));
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first edge did not present the MSB");

  c_load: cover property (@(posedge ssi_clk) disable iff (rst_s2_q) load ##1 !load);

endmodule // aeol_ssi_shift

// [aeol_ssi_ctrl_model.sv]
/*
  Behavioural model of the serial controller that reads position frames.
  Assumes the bench pulses start once per frame and waits for done.
*/
`timescale 1ns/1ps
module aeol_ssi_ctrl_model (
  // Bench control
  input  wire logic        start,
  input  wire logic        free_run,
  input  wire logic [4:0]  stall_after,
  // Serial link
  output logic             ssi_clk,
  output logic             frame_select_low,
  input  wire logic        ssi_data_out,
  input  wire logic        ssi_data_oe_n,
  // Result
  output logic [15:0]      word,
  output logic             done
);
  logic last;

  initial begin
    ssi_clk = 1'b1;
    frame_select_low = 1'b1;
    word = 16'h0000;
    done = 1'b0;
    last = 1'b0;
  end

  // ==========================================================================
  // Clock runs free while free_run is set, through reset and until the link side has left it
  always #40 begin
    if (free_run) begin
      ssi_clk = ~ssi_clk;
    end else if (frame_select_low) begin
      ssi_clk = 1'b1;
    end
  end

  // ==========================================================================
  // One frame; a stall with the clock low outlasts the frame timeout
  always @(posedge start) begin
    done = 1'b0;
    frame_select_low = 1'b0;
    #600;
    for (int i = 0; i < 16; i++) begin
      ssi_clk = 1'b0;
      if (i == stall_after) #25000;
      #40;
      ssi_clk = 1'b1;
      #40;
      // A released line reads as a changing pattern, not the last bit
      last = ssi_data_oe_n ? ~last : ssi_data_out;
      word = {word[14:0], last};
    end
    frame_select_low = 1'b1;
    #20000;
    done = 1'b1;
  end
endmodule // aeol_ssi_ctrl_model

// [tb_top.sv]
/*
  Self-checking bench for the angle encoder output logic.
  Assumes aeol_pkg, the design and the serial controller model compile first.
*/
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  localparam int SC = 50;
  logic        core_clk        = 1'b0;
  logic        reset           = 1'b1;
  logic [15:0] pos_in          = 16'h0000;
  logic [15:0] pos_val         = 16'h0000;
  logic        pos_valid       = 1'b0;
  logic        inc_en          = 1'b1;
  logic        comm_en         = 1'b0;
  logic        pwm_en          = 1'b0;
  logic [2:0]  cpr_sel         = 3'h0;
  logic [1:0]  iw_sel          = 2'h3;
  logic [1:0]  pp_sel          = 2'h0;
  logic        start           = 1'b0;
  logic        free_run        = 1'b1;
  logic [4:0]  stall           = 5'h10;
  logic [31:0] mismatches      = 0;
  logic [31:0] samples_checked = 0;
  logic [31:0] cycles          = 0;
  logic        sample_req, pos_ready, ssi_clk, fsl, sdo, sdo_oe_n, fs, done;
  logic        qa, qb, qi, cu, cv, cw, pwm_out;
  logic [11:0] inc_count, c0;
  logic [15:0] word;
  logic [31:0] n, hits, ton, toff;
  logic [1:0]  ab;

  always #10 core_clk = ~core_clk;

  // Front end answers each sample request one cycle later
  always @(negedge core_clk) begin
    pos_valid <= sample_req;
    pos_in    <= pos_val;
  end

  aeol_top #(.SAMPLE_CYCLES(SC)) dut (
    .core_clk(core_clk), .reset(reset), .pos_in(pos_in), .pos_valid(pos_valid),
    .sample_req(sample_req), .pos_ready(pos_ready), .ssi_clk(ssi_clk),
    .frame_select_low(fsl), .ssi_data_out(sdo), .ssi_data_oe_n(sdo_oe_n),
    .inc_enable(inc_en), .comm_enable(comm_en), .pwm_enable(pwm_en),
    .cpr_sel(cpr_sel), .index_width_sel(iw_sel), .pole_pair_sel(pp_sel),
    .quad_a(qa), .quad_b(qb), .quad_index(qi), .inc_count(inc_count),
    .comm_u(cu), .comm_v(cv), .comm_w(cw), .pwm_out(pwm_out));

  aeol_ssi_ctrl_model ctrl (
    .start(start), .free_run(free_run), .stall_after(stall), .ssi_clk(ssi_clk),
    .frame_select_low(fsl), .ssi_data_out(sdo), .ssi_data_oe_n(sdo_oe_n),
    .word(word), .done(done));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Two edges first so the answered sample surely carries the new value
  task automatic set_pos(input logic [15:0] v);
    pos_val = v;
    cyc(2);
    for (int i = 0; i < 4 * SC && pos_valid !== 1'b1; i++) cyc(1);
    cyc(3);
  endtask

  task automatic run_frame(input logic [15:0] v, input logic [4:0] st);
    set_pos(v);
    stall = st;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    for (n = 0; n < 20 && sdo_oe_n !== 1'b0; n++) cyc(1);
    for (n = 0; n < 3000 && sdo_oe_n !== 1'b1; n++) cyc(1);
    fs = fsl;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) cyc(1);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked != 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_sample;
    for (n = 0; n < 200 && sample_req !== 1'b1; n++) cyc(1);
    cyc(1);
    for (n = 1; n < 200 && sample_req !== 1'b1; n++) cyc(1);
    chk(n, SC);
    cyc(3);
    chk(pos_ready, 1'b1);
  endtask

  // Step three quarter counts up and back at every resolution
  task automatic t_cpr;
    for (int s = 0; s < 8; s++) begin
      cpr_sel = s[2:0];
      cyc(2 * SC);
      c0 = inc_count;
      for (int k = 1; k <= 3; k++) set_pos(16'(k * (2048 >> s)));
      chk(12'(inc_count - c0), 12'h003);
      for (int k = 2; k >= 0; k--) set_pos(16'(k * (2048 >> s)));
      chk(12'(inc_count - c0), 12'h000);
    end
  endtask

  task automatic t_index;
    for (int w = 0; w < 4; w++) begin
      iw_sel = w[1:0];
      set_pos(16'hFFC0);
      cyc(16 * SC);
      hits = 0;
      for (int k = 1; k <= 12; k++) begin
        ab = {qa, qb};
        set_pos(16'(32'hFFC0 + k * 16));
        chk($countones(ab ^ {qa, qb}), 1);
        hits = hits + qi;
      end
      chk(hits, 32'(w + 1));
      chk(inc_count, 12'h008);
    end
  endtask

  task automatic t_comm;
    comm_en = 1'b1;
    for (int p = 0; p < 4; p++) begin
      pp_sel = p[1:0];
      for (int s = 0; s < 6; s++) begin
        set_pos(16'((2 * s + 1) * 65536 / (12 << p)));
        chk({cu, cv, cw}, aeol_pkg::HALL_PATTERN[s]);
      end
    end
  endtask

  task automatic t_serial;
    run_frame(16'hA5C3, 5'h10);
    chk(word, 16'hA5C3);
    chk(fs, 1'b1);
    run_frame(16'h5A3C, 5'h10);
    chk(word, 16'h5A3C);
    chk(sdo_oe_n, 1'b1);
  endtask

  // Low data trips the hold limit well before the timeout would
  task automatic t_watchdog;
    run_frame(16'h0000, 5'h04);
    chk(fs, 1'b0);
    chk(n < 750, 1'b1);
    run_frame(16'hFFFF, 5'h04);
    chk(fs, 1'b0);
    chk(n >= 750 && n < 1100, 1'b1);
  endtask

  task automatic t_pwm;
    pwm_en = 1'b1;
    set_pos(16'hFF00);
    for (n = 0; n < 13000 && pwm_out !== 1'b0; n++) cyc(1);
    for (n = 0; n < 13000 && pwm_out !== 1'b1; n++) cyc(1);
    for (ton = 0; ton < 13000 && pwm_out === 1'b1; ton++) cyc(1);
    for (toff = 0; toff < 13000 && pwm_out === 1'b0; toff++) cyc(1);
    chk(ton, 32'd12252);
    chk(ton * 1025 / (ton + toff) - 1, 32'd1020);
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 32'd100000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end

  // Reset spans three link clock edges so the link side sees it, and the
  // link clock keeps running after release until that side has left reset;
  // a clock stopped too soon would keep the shift stage in reset into the
  // first frame and lose its leading bits.
  initial begin
    cyc(13);
    chk(sdo_oe_n, 1'b1);
    chk({sdo, qa, qb, qi, cu, cv, cw, pwm_out}, 8'h80);
    reset = 1'b0;
    cyc(16);
    free_run = 1'b0;
    cyc(2);
    t_sample;
    t_cpr;
    t_index;
    t_comm;
    t_serial;
    t_watchdog;
    t_pwm;
    print_verdict;
  end
endmodule // tb_top
